// *** design/buck_gate_drive_control.v ***
`include "buck_gate_drive_defines.vh"
`default_nettype none
// Summary of operation
// - high skip select enables zero-current mid mode
// - high command: low gate off, then high
// - mid: low gate on, hold blank plus debounce
// - after blanking, zero current turns low off
// - disable release starts 25 us calibration
// - sensed gates and switch node time non-overlap
// - rising: low off, sensed off, timer, high
// - falling: high off, sensed off, timer, low
// - mid skip select biases command to mid
// - open disable means disabled, no high drive
// - lockout or disable holds both gates off
// - enable only after supply lockout releases
// - thermal warning low, keep switching
// - thermal shutdown forces gates off
// - mid with low skip: both off immediately
// - early zero current ignored until wait ends
// - mid skip select acts like high select
module buck_gate_drive_control #(
  parameter CAL_CYCLES = `CAL_CYCLES
) (
  // clock and reset
  input wire i_clk,
  input wire i_rst,
  // pre-decoded three-level pwm command
  input wire i_pwm_low,
  input wire i_pwm_mid,
  input wire i_pwm_high,
  // pre-decoded skip_mode_select
  input wire i_skip_low,
  input wire i_skip_mid,
  input wire i_skip_high,
  // enable, lockout and thermal (analog side, decoded)
  input wire i_disable_n,
  input wire i_supply_lockout,
  input wire i_over_warn_temperature,
  input wire i_over_shutdown_temperature,
  // gate-off sensing and zero-current comparator
  input wire i_high_gate_sensed_off,
  input wire i_low_gate_sensed_off,
  input wire i_switch_node_low,
  input wire i_zero_current_detect,
  // outputs
  output reg o_high_gate_drive,
  output reg o_low_gate_drive,
  output reg o_thermal_warn_n_oe,
  output reg o_pwm_bias_en,
  output reg o_calibrating,
  output reg o_enabled
);
  ////////////////////////////////////////////////////////////////////////////
  wire [11:0] raw_in;
  wire [11:0] syn;
  assign raw_in = {i_pwm_low, i_pwm_mid, i_pwm_high, i_skip_low, i_skip_mid,
    i_skip_high, i_disable_n, i_supply_lockout, i_over_warn_temperature,
    i_over_shutdown_temperature, i_zero_current_detect, i_switch_node_low};
  // pins cross into the clock domain before any logic looks at them
  sync2 #(.W(12)) u_sync (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_d(raw_in),
    .o_q(syn)
  );
  wire pwm_low = syn[11];
  wire pwm_mid = syn[10];
  wire pwm_high = syn[9];
  wire skip_low = syn[8];
  wire skip_mid = syn[7];
  wire skip_high = syn[6];
  wire disable_n = syn[5]; // low after reset and when open
  wire lockout = syn[4];
  wire warn = syn[3];
  wire shut = syn[2];
  wire zero_cur = syn[1];
  wire sw_low = syn[0];
  wire [1:0] off_syn;
  sync2 #(.W(2)) u_sync_sense (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_d({i_high_gate_sensed_off, i_low_gate_sensed_off}),
    .o_q(off_syn)
  );
  // the high switch is off only if its gate is low and the node agrees; the low switch uses its gate alone
  wire hs_off = off_syn[1] & sw_low;
  wire ls_off = off_syn[0];
  ////////////////////////////////////////////////////////////////////////////
  // mid skip select behaves as high apart from the bias; an all-low
  // decode is an open pin, which its pull-up holds high
  wire zcd_mode = skip_high | skip_mid | ~skip_low;
  // enable needs lockout released and disable driven high
  wire run = ~lockout & disable_n & ~shut;
  // driver states
  localparam [2:0] ST_OFF = 3'h0;
  localparam [2:0] ST_HS_WAIT = 3'h1;
  localparam [2:0] ST_HS_ON = 3'h2;
  localparam [2:0] ST_LS_WAIT = 3'h3;
  localparam [2:0] ST_LS_ON = 3'h4;
  // low gate cut by zero current; stays off until the command leaves mid
  localparam [2:0] ST_LS_DONE = 3'h5;
  // timer loads sized to the timer so no bits are dropped
  localparam [8:0] NOL_LOAD = `NOL_CYCLES;
  localparam [8:0] BLANK_LOAD = `BLANK_CYCLES;
  // low command, or mid in zero-current mode, asks for the low gate
  function low_wanted;
    input lvl_low;
    input lvl_mid;
    input zc_mode;
    begin
      low_wanted = lvl_low | (lvl_mid & zc_mode);
    end
  endfunction
  reg [2:0] state_reg;
  reg [2:0] state_next;
  reg [8:0] tmr_reg;
  reg [8:0] tmr_next;
  reg hs_next;
  reg ls_next;
  reg cal_reg;
  always @* begin
    state_next = state_reg;
    tmr_next = (tmr_reg == 9'h000) ? 9'h000 : tmr_reg - 9'h001;
    hs_next = 1'b0;
    ls_next = 1'b0;
    if (!run) begin
      state_next = ST_OFF;
    end else begin
      case (state_reg)
        ST_OFF: begin
          if (pwm_high) begin
            state_next = ST_HS_WAIT;
            tmr_next = NOL_LOAD;
          end else if (low_wanted(pwm_low, pwm_mid, zcd_mode)) begin
            state_next = ST_LS_WAIT;
            tmr_next = NOL_LOAD;
          end
        end
        ST_HS_WAIT: begin
          // low gate already dropped; wait for sense then timer
          if (!pwm_high) begin
            state_next = ST_OFF;
          end else if (!ls_off) begin
            tmr_next = NOL_LOAD;
          end else if (tmr_reg == 9'h000) begin
            state_next = ST_HS_ON;
            hs_next = 1'b1;
          end
        end
        ST_HS_ON: begin
          hs_next = pwm_high;
          if (!pwm_high) begin
            state_next = ST_OFF;
          end
        end
        ST_LS_WAIT: begin
          if (!low_wanted(pwm_low, pwm_mid, zcd_mode)) begin
            state_next = ST_OFF;
          end else if (!hs_off) begin
            tmr_next = NOL_LOAD;
          end else if (tmr_reg == 9'h000) begin
            state_next = ST_LS_ON;
            ls_next = 1'b1;
            tmr_next = BLANK_LOAD;
          end
        end
        ST_LS_ON: begin
          ls_next = 1'b1;
          if (pwm_high || (pwm_mid && !zcd_mode)) begin
            // mid with low skip: no delay at all
            state_next = ST_OFF;
            ls_next = 1'b0;
          end else if (pwm_mid && tmr_reg == 9'h000 &&
                       (zero_cur || cal_reg)) begin
            // during calibration threshold is not trusted: end at wait
            state_next = ST_LS_DONE;
            ls_next = 1'b0;
          end else if (pwm_low) begin
            tmr_next = BLANK_LOAD;
          end
        end
        ST_LS_DONE: begin
          // no second low pulse, and no ringing, within one mid period
          if (!pwm_mid) begin
            state_next = ST_OFF;
          end
        end
        default: begin
          state_next = ST_OFF;
        end
      endcase
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // calibration of the zero-current threshold on each rising edge of disable_n
  reg dis_d_reg;
  reg [31:0] cal_cnt_reg;
  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      dis_d_reg <= 1'b0;
      cal_reg <= 1'b0;
      cal_cnt_reg <= 32'h0000_0000;
    end else begin
      dis_d_reg <= disable_n;
      if (disable_n && !dis_d_reg) begin
        cal_reg <= 1'b1;
        cal_cnt_reg <= CAL_CYCLES - 1;
      end else if (cal_cnt_reg != 32'h0000_0000) begin
        cal_cnt_reg <= cal_cnt_reg - 32'h0000_0001;
      end else begin
        cal_reg <= 1'b0;
      end
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      state_reg <= ST_OFF;
      tmr_reg <= 9'h000;
      o_high_gate_drive <= 1'b0;
      o_low_gate_drive <= 1'b0;
      o_thermal_warn_n_oe <= 1'b0;
      o_pwm_bias_en <= 1'b0;
      o_calibrating <= 1'b0;
      o_enabled <= 1'b0;
    end else begin
      state_reg <= state_next;
      tmr_reg <= tmr_next;
      // gates drop at once when run falls; never both on
      o_high_gate_drive <= hs_next & run & ~ls_next;
      o_low_gate_drive <= ls_next & run;
      // hysteresis lives in the analog comparator
      o_thermal_warn_n_oe <= warn;
      o_pwm_bias_en <= skip_mid;
      o_calibrating <= cal_reg;
      o_enabled <= run;
    end
  end
endmodule // buck_gate_drive_control
`default_nettype wire

// *** design/buck_gate_drive_defines.vh ***
`ifndef BUCK_GATE_DRIVE_DEFINES_VH
`define BUCK_GATE_DRIVE_DEFINES_VH
// clock period in ns
`define CLK_PERIOD_NS 10
// non-overlap timer, ns (round up)
`define NOL_TIME_NS 13
`define NOL_CYCLES ((`NOL_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
// detect blanking 250 ns plus debounce 80 ns (least times, round up)
`define BLANK_TIME_NS 250
`define DEBOUNCE_TIME_NS 80
`define BLANK_CYCLES \
  ((`BLANK_TIME_NS + `DEBOUNCE_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
// offset calibration 25 us
`define CAL_TIME_US 25
`define CAL_CYCLES (`CAL_TIME_US * 1000 / `CLK_PERIOD_NS)
`endif

// *** design/sync2.v ***
`default_nettype none
module sync2 #(
  parameter W = 1
) (
  input wire i_clk,
  input wire i_rst,
  input wire [W-1:0] i_d,
  output reg [W-1:0] o_q
);
  reg [W-1:0] meta_reg;
  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      meta_reg <= {W{1'b0}};
      o_q <= {W{1'b0}};
    end else begin
      meta_reg <= i_d;
      o_q <= meta_reg;
    end
  end
endmodule // sync2
`default_nettype wire

// *** tb/buck_gate_drive_control_monitor.sv ***
`default_nettype none
module buck_gate_drive_control_monitor #(
  parameter CAL_CYCLES = 2500
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // command and skip select
  input wire logic i_pwm_low,
  input wire logic i_pwm_mid,
  input wire logic i_pwm_high,
  input wire logic i_skip_low,
  input wire logic i_skip_mid,
  input wire logic i_skip_high,
  // enable, lockout and thermal
  input wire logic i_disable_n,
  input wire logic i_supply_lockout,
  input wire logic i_over_warn_temperature,
  input wire logic i_over_shutdown_temperature,
  // sensing
  input wire logic i_high_gate_sensed_off,
  input wire logic i_low_gate_sensed_off,
  input wire logic i_switch_node_low,
  input wire logic i_zero_current_detect,
  // design outputs
  input wire logic o_high_gate_drive,
  input wire logic o_low_gate_drive,
  input wire logic o_thermal_warn_n_oe,
  input wire logic o_pwm_bias_en,
  input wire logic o_calibrating,
  input wire logic o_enabled
);
  timeunit 1ns / 1ns;
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);
  wire hi = o_high_gate_drive;
  wire lo = o_low_gate_drive;
  int cal_cnt;
  always @(posedge i_clk or posedge i_rst)
    if (i_rst) cal_cnt <= 0;
    else cal_cnt <= o_calibrating ? cal_cnt + 1 : 0;
  gate_overlap_a: assert property (!(hi && lo))
    else $error("both gates on");
  high_after_low_a: assert property ($rose(hi) |-> !$past(lo) &&
    !$past(lo, 2) && $past(i_low_gate_sensed_off, 2)) else $error("high early");
  low_after_high_a: assert property ($rose(lo) |-> !$past(hi) &&
    !$past(hi, 2) && $past(i_switch_node_low, 2)) else $error("low early");
  lockout_off_a: assert property (i_supply_lockout[*6] |->
    !hi && !lo && !o_enabled) else $error("run in lockout");
  disable_off_a: assert property (!i_disable_n[*6] |-> !hi && !lo)
    else $error("run while disabled");
  shutdown_off_a: assert property (i_over_shutdown_temperature[*6] |->
    !hi && !lo) else $error("run in shutdown");
  mid_skip_low_a: assert property ((i_pwm_mid && i_skip_low)[*6] |->
    !hi && !lo) else $error("mid not off");
  warn_on_a: assert property (i_over_warn_temperature[*5] |->
    o_thermal_warn_n_oe) else $error("warn missing");
  warn_off_a: assert property (!i_over_warn_temperature[*5] |->
    !o_thermal_warn_n_oe) else $error("warn stuck");
  bias_follow_a: assert property (i_skip_mid[*5] |-> o_pwm_bias_en)
    else $error("bias missing");
  cal_start_a: assert property ($rose(i_disable_n) |-> ##[1:5] o_calibrating)
    else $error("no calibration");
  cal_length_a: assert property (cal_cnt <= CAL_CYCLES + 1)
    else $error("calibration too long");
  cover property ($rose(hi));
  cover property ($rose(lo));
  cover property ($fell(o_calibrating));
endmodule // buck_gate_drive_control_monitor
bind buck_gate_drive_control buck_gate_drive_control_monitor #(
  .CAL_CYCLES(CAL_CYCLES)
) monitor_inst (
  .i_clk(i_clk),
  .i_rst(i_rst),
  .i_pwm_low(i_pwm_low),
  .i_pwm_mid(i_pwm_mid),
  .i_pwm_high(i_pwm_high),
  .i_skip_low(i_skip_low),
  .i_skip_mid(i_skip_mid),
  .i_skip_high(i_skip_high),
  .i_disable_n(i_disable_n),
  .i_supply_lockout(i_supply_lockout),
  .i_over_warn_temperature(i_over_warn_temperature),
  .i_over_shutdown_temperature(i_over_shutdown_temperature),
  .i_high_gate_sensed_off(i_high_gate_sensed_off),
  .i_low_gate_sensed_off(i_low_gate_sensed_off),
  .i_switch_node_low(i_switch_node_low),
  .i_zero_current_detect(i_zero_current_detect),
  .o_high_gate_drive(o_high_gate_drive),
  .o_low_gate_drive(o_low_gate_drive),
  .o_thermal_warn_n_oe(o_thermal_warn_n_oe),
  .o_pwm_bias_en(o_pwm_bias_en),
  .o_calibrating(o_calibrating),
  .o_enabled(o_enabled)
);
`default_nettype wire

// *** tb/pwm_controller_model.sv ***
`default_nettype none
module pwm_controller_model (
  // clock and requested level: 0 low, 1 mid, 2 high
  input wire logic i_clk,
  input wire logic [1:0] i_level,
  // gates seen from the power stage
  input wire logic i_high_gate,
  input wire logic i_low_gate,
  // one-hot command
  output logic o_pwm_low,
  output logic o_pwm_mid,
  output logic o_pwm_high,
  // stage sensing: high means gate off or node low
  output logic o_high_off,
  output logic o_low_off,
  output logic o_sw_low
);
  timeunit 1ns / 1ns;
  logic [1:0] level_reg = 2'h1;
  // level taken on the rising edge so a falling-edge write never races
  always @(posedge i_clk) level_reg <= i_level;
  // gates take a cycle to discharge; switch node lags the high gate once more
  initial begin
    {o_pwm_high, o_pwm_mid, o_pwm_low} = 3'h2;
    {o_high_off, o_low_off, o_sw_low} = 3'h7;
    forever begin
      @(negedge i_clk);
      {o_pwm_high, o_pwm_mid, o_pwm_low} <= 3'h1 << level_reg;
      o_high_off <= !i_high_gate;
      o_low_off <= !i_low_gate;
      o_sw_low <= o_high_off;
    end
  end
endmodule // pwm_controller_model
`default_nettype wire

// *** tb/buck_gate_drive_control_tb.sv ***
`default_nettype none
module buck_gate_drive_control_tb;
  timeunit 1ns / 1ns;
  logic i_clk = 0, i_rst = 1, dis_n = 0, lock = 1, warn = 0, shut = 0, zc = 0;
  logic hi, lo, oe, bias, cal, en, pl, pm, ph, hso, lso, swl;
  logic [2:0] skip = 3'h4;
  logic [1:0] lvl = 2'h2, e;
  int bad_count = 0, n_checks = 0, k;
  always #5 i_clk = ~i_clk;
  pwm_controller_model pwm_controller_model_inst (.i_clk(i_clk),
    .i_level(lvl), .i_high_gate(hi), .i_low_gate(lo), .o_pwm_low(pl),
    .o_pwm_mid(pm), .o_pwm_high(ph), .o_high_off(hso), .o_low_off(lso),
    .o_sw_low(swl));
  buck_gate_drive_control #(.CAL_CYCLES(10)) buck_gate_drive_control_inst (
    .i_clk(i_clk), .i_rst(i_rst), .i_pwm_low(pl), .i_pwm_mid(pm),
    .i_pwm_high(ph), .i_skip_low(skip[0]), .i_skip_mid(skip[1]),
    .i_skip_high(skip[2]), .i_disable_n(dis_n), .i_supply_lockout(lock),
    .i_over_warn_temperature(warn), .i_over_shutdown_temperature(shut),
    .i_high_gate_sensed_off(hso), .i_low_gate_sensed_off(lso),
    .i_switch_node_low(swl), .i_zero_current_detect(zc),
    .o_high_gate_drive(hi), .o_low_gate_drive(lo), .o_thermal_warn_n_oe(oe),
    .o_pwm_bias_en(bias), .o_calibrating(cal), .o_enabled(en));
  task automatic stop_test;
    if (bad_count == 0 && n_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input logic c, input string m);
    n_checks++;
    if (c !== 1'b1) begin
      bad_count++;
      $display("unexpected at %0t: %s", $time, m);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge i_clk);
  endtask
  // watched signal: 0 calibrating, 1 low gate
  function automatic logic pick(input int w);
    return (w == 0) ? cal : lo;
  endfunction
  // bounded wait; the cycle count doubles as a duration measure
  task automatic wait_sig(input int w, input logic v, output int c);
    for (c = 0; c < 60 && pick(w) !== v; c++) tick(1);
    if (c == 60) begin
      chk(1'b0, "wait bound");
      stop_test;
    end
  endtask
  // {high, low} once settled; mid with zero current absent keeps low on unless skip is low
  function automatic logic [1:0] exp_gates(logic [1:0] l, logic [2:0] s);
    if (l == 2'h2) return 2'b10;
    if (l == 2'h0) return 2'b01;
    return s[0] ? 2'b00 : 2'b01;
  endfunction
  initial begin
    k = $urandom(32'h8492);
    tick(10);
    i_rst = 0;
    tick(3);
    lock = 0;
    dis_n = 1;
    wait_sig(0, 1'b1, k);
    wait_sig(0, 1'b0, k);
    chk(k inside {[10:11]}, "calibration length");
    for (int i = 0; i < 40; i++) begin
      lvl = 2'($urandom_range(2));
      skip = 3'h1 << $urandom_range(2);
      warn = 1'($urandom_range(1));
      tick(20);
      e = exp_gates(lvl, skip);
      chk({hi, lo} === e, "gates");
      chk(oe === warn && bias === skip[1], "warn or bias");
    end
    skip = 3'h4;
    lvl = 2'h2;
    tick(20);
    zc = 1;
    lvl = 2'h1;
    wait_sig(1, 1'b1, k);
    wait_sig(1, 1'b0, k);
    chk(k inside {[33:34]}, "blanking hold");
    zc = 0;
    lvl = 2'h2;
    tick(20);
    lvl = 2'h1;
    tick(50);
    chk(lo === 1'b1, "low gate held");
    zc = 1;
    tick(6);
    chk(lo === 1'b0, "zero current cut");
    tick(20);
    chk(lo === 1'b0, "low gate stays off");
    zc = 0;
    lvl = 2'h2;
    for (int f = 0; f < 3; f++) begin
      tick(20);
      {lock, dis_n, shut} = f == 0 ? 3'b110 : (f == 1 ? 3'b000 : 3'b011);
      tick(8);
      chk({hi, lo} === 2'b00, "fault gates");
      chk(en === 1'b0, "enabled in fault");
      {lock, dis_n, shut} = 3'b010;
    end
    tick(20);
    chk(hi === 1'b1, "resume");
    chk(en === 1'b1, "not enabled");
    stop_test;
  end
endmodule // buck_gate_drive_control_tb
`default_nettype wire
